// *** inc/ptc_pkg.sv ***
// shared constants and types of the periodic timer with compare and capture
package ptc_pkg;

    // ********************************************************************
    // counter geometry and register map (byte addresses on the bus)
    // ********************************************************************
    localparam int PTC_CNT_W = 10; // counter and compare width
    localparam logic [5:0] PTC_OFS_CTL0 = 6'h00; // enable
    localparam logic [5:0] PTC_OFS_CTL1 = 6'h04; // timer_control_one
    localparam logic [5:0] PTC_OFS_CNTL = 6'h08; // count_low_byte
    localparam logic [5:0] PTC_OFS_CNTH = 6'h0C; // count_high_bits
    localparam logic [5:0] PTC_OFS_DUTL = 6'h10; // duty_compare_low_byte
    localparam logic [5:0] PTC_OFS_DUTH = 6'h14; // duty_compare_high_bits
    localparam logic [5:0] PTC_OFS_PERL = 6'h18; // period_compare_low_byte
    localparam logic [5:0] PTC_OFS_PERH = 6'h1C; // period_compare_high_bits
    localparam logic [5:0] PTC_OFS_STAT = 6'h20; // match flags, w1c

    // ********************************************************************
    // field positions and reset values
    // ********************************************************************
    localparam int PTC_EN_BIT = 3; // counter_enable_bit in control 0
    localparam int PTC_DFLAG_BIT = 0; // duty_match_flag in status
    localparam int PTC_PFLAG_BIT = 1; // period_match_flag in status
    localparam logic [7:0] PTC_CTL1_RST = 8'h00;
    localparam logic [7:0] PTC_BYTE_RST = 8'h00;

    // operating mode field, bits 7..6 of control 1
    typedef enum logic [1:0] {
        PTC_MODE_CMP = 2'b00, // compare match output
        PTC_MODE_CAP = 2'b01, // capture input
        PTC_MODE_PWM = 2'b10, // pwm or single pulse
        PTC_MODE_TMR = 2'b11 // timer/counter
    } ptc_mode_type;

    // output function codes in compare match mode
    localparam logic [1:0] PTC_IO_NONE = 2'b00;
    localparam logic [1:0] PTC_IO_LOW = 2'b01;
    localparam logic [1:0] PTC_IO_HIGH = 2'b10;
    localparam logic [1:0] PTC_IO_TOGGLE = 2'b11;

    // capture edge codes, same field in capture mode
    localparam logic [1:0] PTC_EDGE_RISE = 2'b00;
    localparam logic [1:0] PTC_EDGE_FALL = 2'b01;
    localparam logic [1:0] PTC_EDGE_BOTH = 2'b10;
    localparam logic [1:0] PTC_EDGE_OFF = 2'b11;

    // pwm output function codes
    localparam logic [1:0] PTC_PWM_INACT = 2'b00;
    localparam logic [1:0] PTC_PWM_ACT = 2'b01;
    localparam logic [1:0] PTC_PWM_RUN = 2'b10;

    // control 1 layout, msb first
    typedef struct packed {
        ptc_mode_type mode; // operating_mode_bit1/0
        logic [1:0] io; // output_function_bit1/0
        logic oc; // output_control_bit
        logic pol; // output_polarity_bit
        logic cks; // capture_source_select
        logic cclr; // clear_select_bit
    } ptc_ctl1_type;

endpackage

// *** src/ptc_timer.sv ***
// periodic timer: counter, duty/period comparators, capture, avalon slave
// Operation
// - edge code picks rise, fall, both, none
// - duty match sets, clears or toggles output
// - function codes: 01 low, 10 high, 11 toggle
// - requested level equal initial gives no change
// - enable rising edge restores initial output level
// - control bit: initial level or active level
// - polarity bit inverts output pin
// - source bit picks capture pin or clock pin
// - clear select: duty match or period/overflow
// - overflow clearing only with zero period value
// - clear select ignored in pwm, capture modes
// - counter readable as low byte, high bits
// - duty compare value in two registers
// - period compare value in two registers
// - mode code 00 is compare match output
// - mode codes: capture, pwm, timer/counter
// - both flags raised when clear select low
// - clear select high: period flag never set in compare, timer modes
// - zero duty value: overflow, no duty flag
// - duty match or enable rise moves the output level
// - enable rise clears counter, fall holds it
//
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps

module ptc_timer
    import ptc_pkg::*;
#(
    parameter int CNT_W = PTC_CNT_W // counter width, 9 to 16
)
(
    input wire logic i_clk, // timer and bus clock
    input wire logic i_rst_b, // synchronous reset, active low
    input wire logic [5:0] i_avs_address, // byte address
    input wire logic i_avs_read, // read request
    input wire logic i_avs_write, // write request
    input wire logic [31:0] i_avs_writedata, // write data
    input wire logic [3:0] i_avs_byteenable, // lane 0 carries data
    output logic [31:0] o_avs_readdata, // read data
    output logic o_avs_waitrequest, // stall
    input wire logic i_capture_input_pin, // dedicated capture pin
    input wire logic i_external_clock_pin, // alternate capture pin
    output logic o_timer_output_pin, // timer output
    output logic o_timer_output_inverted_pin, // complement of output
    output logic o_timer_output_enable // high while output is driven
);

    // ********************************************************************
    // elaboration check
    // ********************************************************************
    // high registers hold at most eight bits above the low byte
    if (CNT_W < 9 || CNT_W > 16)
    begin : g_bad_width
        $error("CNT_W must lie between 9 and 16");
    end

    localparam logic [CNT_W-1:0] CNT_MAX = '1; // overflow point

    // ********************************************************************
    // declarations
    // ********************************************************************
    logic en_reg; // counter_enable_bit
    ptc_ctl1_type ctl_reg; // timer_control_one
    logic [CNT_W-1:0] cnt_reg; // running count
    logic [CNT_W-1:0] duty_reg; // duty_compare_value
    logic [CNT_W-1:0] per_reg; // period_compare_value
    logic dflag_reg; // duty_match_flag
    logic pflag_reg; // period_match_flag
    logic lvl_reg; // compare-mode output level, before polarity
    logic cap_prev_reg; // last sample of capture source
    logic ack_reg; // bus answer phase
    logic [31:0] rdata_reg; // registered read data
    logic pin_reg; // registered output
    logic pinb_reg; // registered complement
    logic oe_reg; // registered drive enable
    logic lvl_next; // next compare-mode level
    logic pin_next; // next pin level
    logic [31:0] rdata_next; // read mux
    logic wr_go; // write takes effect this edge
    logic lane0; // low byte lane enabled
    logic en_rise; // enable goes low to high
    logic en_fall; // enable cleared by software
    logic duty_hit; // duty comparator match
    logic per_hit; // period comparator match
    logic cnt_clr; // counter clears at this edge
    logic cap_src; // selected capture source
    logic cap_evt; // capture edge accepted
    logic dflag_set; // duty flag source
    logic pflag_set; // period flag source
    logic sp_stop; // single pulse ends on duty match

    // ********************************************************************
    // avalon slave: one wait state, then the answer edge
    // ********************************************************************
    // a single wait state lets read data come from a flop
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
    assign o_avs_readdata = rdata_reg;
    assign wr_go = i_avs_write & ack_reg;
    assign lane0 = i_avs_byteenable[0];

    // answer phase toggles on for one cycle per request
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            ack_reg <= 1'b0;
        else
            ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
    end

    // read mux, unmapped and reserved bits read zero
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        case (i_avs_address)
            PTC_OFS_CTL0: rdata_next[PTC_EN_BIT] = en_reg;
            PTC_OFS_CTL1: rdata_next[7:0] = ctl_reg;
            PTC_OFS_CNTL: rdata_next[7:0] = cnt_reg[7:0];
            PTC_OFS_CNTH: rdata_next = 32'(cnt_reg >> 8);
            PTC_OFS_DUTL: rdata_next[7:0] = duty_reg[7:0];
            PTC_OFS_DUTH: rdata_next = 32'(duty_reg >> 8);
            PTC_OFS_PERL: rdata_next[7:0] = per_reg[7:0];
            PTC_OFS_PERH: rdata_next = 32'(per_reg >> 8);
            PTC_OFS_STAT:
            begin
                rdata_next[PTC_DFLAG_BIT] = dflag_reg;
                rdata_next[PTC_PFLAG_BIT] = pflag_reg;
            end
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // read data sampled in the wait cycle, stands through the answer
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            rdata_reg <= 32'h0000_0000;
        else if (i_avs_read && !ack_reg)
            rdata_reg <= rdata_next;
    end

    // ********************************************************************
    // control registers
    // ********************************************************************
    assign en_rise = wr_go && lane0 && i_avs_address == PTC_OFS_CTL0
        && i_avs_writedata[PTC_EN_BIT] && !en_reg;
    assign en_fall = wr_go && lane0 && i_avs_address == PTC_OFS_CTL0
        && !i_avs_writedata[PTC_EN_BIT];

    // enable; single pulse drops it on its own at duty match
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            en_reg <= 1'b0;
        else if (en_rise)
            en_reg <= 1'b1;
        else if (en_fall || sp_stop)
            en_reg <= 1'b0;
    end

    // mode and pin setup; pwm function is only safe to change when off
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            ctl_reg <= PTC_CTL1_RST;
        else if (wr_go && lane0 && i_avs_address == PTC_OFS_CTL1)
            ctl_reg <= i_avs_writedata[7:0];
    end

    // ********************************************************************
    // comparators and capture source
    // ********************************************************************
    // zero duty never matches, so the counter just rolls over
    assign duty_hit = en_reg && cnt_reg == duty_reg
        && duty_reg != '0;
    // zero period never matches; overflow wrap does the clearing
    assign per_hit = en_reg && cnt_reg == per_reg
        && per_reg != '0;
    assign sp_stop = duty_hit && ctl_reg.mode == PTC_MODE_PWM
        && ctl_reg.io == PTC_EDGE_OFF;

    assign cap_src = ctl_reg.cks ? i_external_clock_pin
        : i_capture_input_pin;

    // edge selection for capture
    always_comb
    begin
        cap_evt = 1'b0;
        if (ctl_reg.mode == PTC_MODE_CAP && en_reg)
        begin
            case (ctl_reg.io)
                PTC_EDGE_RISE: cap_evt = cap_src & ~cap_prev_reg;
                PTC_EDGE_FALL: cap_evt = ~cap_src & cap_prev_reg;
                PTC_EDGE_BOTH: cap_evt = cap_src ^ cap_prev_reg;
                default: cap_evt = 1'b0;
            endcase
        end
    end

    // previous sample of the capture source
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            cap_prev_reg <= 1'b0;
        else
            cap_prev_reg <= cap_src;
    end

    // ********************************************************************
    // counter
    // ********************************************************************
    // clear source per mode
    always_comb
    begin
        case (ctl_reg.mode)
            PTC_MODE_CMP, PTC_MODE_TMR:
                cnt_clr = ctl_reg.cclr ? duty_hit : per_hit;
            default:
                cnt_clr = per_hit;
        endcase
    end

    // counting, cleared on enable rise, held while off
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            cnt_reg <= '0;
        else if (en_rise)
            cnt_reg <= '0;
        else if (en_reg && !sp_stop)
        begin
            if (cnt_clr)
                cnt_reg <= '0;
            else
                cnt_reg <= cnt_reg + 1'b1; // wraps past CNT_MAX
        end
    end

    // ********************************************************************
    // compare value registers, capture loads the duty value
    // ********************************************************************
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            duty_reg <= '0;
        else if (cap_evt)
            duty_reg <= cnt_reg;
        else if (wr_go && lane0 && i_avs_address == PTC_OFS_DUTL)
            duty_reg[7:0] <= i_avs_writedata[7:0];
        else if (wr_go && lane0 && i_avs_address == PTC_OFS_DUTH)
            duty_reg[CNT_W-1:8] <= i_avs_writedata[CNT_W-9:0];
    end

    // period value
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            per_reg <= '0;
        else if (wr_go && lane0 && i_avs_address == PTC_OFS_PERL)
            per_reg[7:0] <= i_avs_writedata[7:0];
        else if (wr_go && lane0 && i_avs_address == PTC_OFS_PERH)
            per_reg[CNT_W-1:8] <= i_avs_writedata[CNT_W-9:0];
    end

    // ********************************************************************
    // match flags, write one to clear, a new event wins
    // ********************************************************************
    assign dflag_set = ctl_reg.mode == PTC_MODE_CAP ? cap_evt : duty_hit;
    assign pflag_set = per_hit && (ctl_reg.mode == PTC_MODE_CAP
        || ctl_reg.mode == PTC_MODE_PWM || !ctl_reg.cclr);

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            dflag_reg <= 1'b0;
            pflag_reg <= 1'b0;
        end
        else
        begin
            if (dflag_set)
                dflag_reg <= 1'b1;
            else if (wr_go && lane0 && i_avs_address == PTC_OFS_STAT
                && i_avs_writedata[PTC_DFLAG_BIT])
                dflag_reg <= 1'b0;
            if (pflag_set)
                pflag_reg <= 1'b1;
            else if (wr_go && lane0 && i_avs_address == PTC_OFS_STAT
                && i_avs_writedata[PTC_PFLAG_BIT])
                pflag_reg <= 1'b0;
        end
    end

    // ********************************************************************
    // output logic
    // ********************************************************************
    // compare-mode level: a duty match or an enable rise moves it
    always_comb
    begin
        lvl_next = lvl_reg;
        if (en_rise)
            lvl_next = ctl_reg.oc;
        else if (ctl_reg.mode == PTC_MODE_CMP && duty_hit)
        begin
            case (ctl_reg.io)
                PTC_IO_LOW: lvl_next = 1'b0; // no edge if already low
                PTC_IO_HIGH: lvl_next = 1'b1;
                PTC_IO_TOGGLE: lvl_next = ~lvl_reg;
                default: lvl_next = lvl_reg;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            lvl_reg <= 1'b0;
        else
            lvl_reg <= lvl_next;
    end

    // pin level per mode; control bit gives the active level in pwm
    always_comb
    begin
        case (ctl_reg.mode)
            PTC_MODE_CMP: pin_next = lvl_reg ^ ctl_reg.pol;
            PTC_MODE_PWM:
            begin
                case (ctl_reg.io)
                    PTC_PWM_INACT: pin_next = ~ctl_reg.oc;
                    PTC_PWM_ACT: pin_next = ctl_reg.oc;
                    // zero period is a full wrap, so it never forces 100%
                    PTC_PWM_RUN: pin_next = (en_reg && (cnt_reg < duty_reg
                        || (per_reg != '0 && duty_reg >= per_reg)))
                        ? ctl_reg.oc : ~ctl_reg.oc;
                    default: pin_next = en_reg ? ctl_reg.oc : ~ctl_reg.oc;
                endcase
                pin_next = pin_next ^ ctl_reg.pol;
            end
            default: pin_next = 1'b0; // pin unused in capture and timer
        endcase
    end

    // registered pins; the pin is released in capture and timer modes
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            pin_reg <= 1'b0;
            pinb_reg <= 1'b1;
            oe_reg <= 1'b0;
        end
        else
        begin
            pin_reg <= pin_next;
            pinb_reg <= ~pin_next;
            oe_reg <= ctl_reg.mode == PTC_MODE_CMP
                || ctl_reg.mode == PTC_MODE_PWM;
        end
    end

    assign o_timer_output_pin = pin_reg;
    assign o_timer_output_inverted_pin = pinb_reg;
    assign o_timer_output_enable = oe_reg;

    // ********************************************************************
    // assertions
    // ********************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    sequence s_cap_rise;
        ctl_reg.mode == PTC_MODE_CAP && ctl_reg.io == PTC_EDGE_RISE
            && en_reg && !cap_prev_reg && cap_src;
    endsequence

    sequence s_cmp_duty;
        ctl_reg.mode == PTC_MODE_CMP && duty_hit && !en_rise;
    endsequence

    cap_rise_a: assert property (s_cap_rise |=> dflag_reg
        && duty_reg == $past(cnt_reg)) else $error("capture missed");

    cap_off_a: assert property (ctl_reg.mode == PTC_MODE_CAP
        && ctl_reg.io == PTC_EDGE_OFF && !wr_go |=> $stable(duty_reg))
        else $error("capture while disabled");

    out_low_a: assert property (s_cmp_duty ##0
        ctl_reg.io == PTC_IO_LOW |=> !lvl_reg ##1 o_timer_output_pin
        == $past(ctl_reg.pol)) else $error("drive low failed");

    out_hold_a: assert property (ctl_reg.mode == PTC_MODE_CMP
        && !duty_hit && !en_rise |=> $stable(lvl_reg))
        else $error("output moved without duty match");

    init_lvl_a: assert property (en_rise |=>
        lvl_reg == $past(ctl_reg.oc)) else $error("initial level lost");

    clr_duty_a: assert property (s_cmp_duty ##0 ctl_reg.cclr
        |=> cnt_reg == '0) else $error("duty match did not clear");

    no_pflag_a: assert property (ctl_reg.mode == PTC_MODE_CMP
        && ctl_reg.cclr && !pflag_reg |=> !pflag_reg)
        else $error("period flag set with clear select");

    en_clr_a: assert property (en_rise |=> cnt_reg == '0 ##1
        (!en_reg || cnt_reg == CNT_MAX || cnt_reg <= 1))
        else $error("enable rise did not clear counter");

    hold_cnt_a: assert property (!en_reg && !en_rise
        |=> $stable(cnt_reg)) else $error("counter moved while off");

    zero_duty_a: assert property (duty_reg == '0 && !cap_evt
        && ctl_reg.mode == PTC_MODE_CMP |-> !dflag_set)
        else $error("duty flag with zero duty value");

endmodule

// *** bench/ptc_pin_model.sv ***
// far side model: drives the capture and clock pins of the timer
`timescale 1ns/100ps

module ptc_pin_model
(
    input wire logic i_clk, // shared clock
    input wire logic i_cap_lvl, // wanted capture pin level
    input wire logic i_ext_lvl, // wanted clock pin level
    output logic o_capture_input_pin, // to the capture pin
    output logic o_external_clock_pin // to the clock pin
);
    // both pins idle low until the bench moves them
    initial
    begin
        o_capture_input_pin = 1'b0;
        o_external_clock_pin = 1'b0;
    end

    // pins move just after an edge, like a synchronous source; the timer
    // samples them on the following edge
    always @(posedge i_clk)
    begin
        o_capture_input_pin <= i_cap_lvl;
        o_external_clock_pin <= i_ext_lvl;
    end
endmodule

// *** bench/ptc_timer_tb_top.sv ***
// self-checking bench of the periodic timer over its avalon slave
`timescale 1ns/100ps

module ptc_timer_tb_top
    import ptc_pkg::*;
;
    // ****************************************************************
    // signals and instances
    // ****************************************************************
    localparam logic [5:0] OFFS [0:8] = '{PTC_OFS_CTL0, PTC_OFS_CTL1,
        PTC_OFS_CNTL, PTC_OFS_CNTH, PTC_OFS_DUTL, PTC_OFS_DUTH,
        PTC_OFS_PERL, PTC_OFS_PERH, 6'h24}; // last one is unmapped
    logic clk = 1'b0; // 40 mhz
    logic rst_b = 1'b0; // held low at start
    logic [5:0] adr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] be = 4'h1; // only lane 0 carries data
    logic [31:0] rdat;
    logic wait_r;
    logic pin, pin_b, pin_en, cap_pin, ext_pin;
    logic cap_lvl = 1'b0;
    logic ext_lvl = 1'b0;
    logic [31:0] v, w; // read scratch
    logic [1:0] io; // output function under test
    logic oc, pol, lvl;
    int errors = 0;
    int cmp_count = 0;

    ptc_timer u_dut (.i_clk(clk), .i_rst_b(rst_b), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
        .i_avs_byteenable(be), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wait_r), .i_capture_input_pin(cap_pin),
        .i_external_clock_pin(ext_pin), .o_timer_output_pin(pin),
        .o_timer_output_inverted_pin(pin_b), .o_timer_output_enable(pin_en));

    ptc_pin_model u_pins (.i_clk(clk), .i_cap_lvl(cap_lvl),
        .i_ext_lvl(ext_lvl), .o_capture_input_pin(cap_pin),
        .o_external_clock_pin(ext_pin));

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic final_report;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one avalon transfer; request held until waitrequest seen low
    task automatic bus(input logic w_n, input logic [5:0] a,
                       input logic [7:0] d, output logic [31:0] q);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        adr <= a;
        wdat <= {24'h00_0000, d};
        if (w_n)
            wr <= 1'b1;
        else
            rd <= 1'b1;
        // look mid-cycle so the answer edge is the next rising one
        while (!done && n < 40)
        begin
            @(negedge clk);
            done = (wait_r === 1'b0);
            n++;
            @(posedge clk);
        end
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (!done)
        begin
            errors++;
            final_report();
        end
        // idle edge so the next request is a fresh assignment
        @(posedge clk);
    endtask

    task automatic wr8(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, d, w);
    endtask

    task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00, v);
        check(v, exp);
    endtask

    // pin and its complement, looked at once settled
    task automatic pin_chk(input logic exp);
        @(negedge clk);
        check(32'({pin_b, pin}), 32'({~exp, exp}));
        @(posedge clk);
    endtask

    // bounded poll of one status flag
    task automatic wait_flag(input int b);
        int n;
        n = 0;
        v = 32'h0000_0000;
        while (v[b] !== 1'b1 && n < 80)
        begin
            bus(1'b0, PTC_OFS_STAT, 8'h00, v);
            n++;
        end
        check(32'(v[b]), 32'h0000_0001);
    endtask

    // run with given compare values and control, left enabled for cyc cycles
    task automatic run(input logic [7:0] c1, input logic [7:0] du,
                       input logic [7:0] pe, input int cyc);
        wr8(PTC_OFS_CTL1, c1);
        wr8(PTC_OFS_DUTL, du);
        wr8(PTC_OFS_PERL, pe);
        wr8(PTC_OFS_STAT, 8'h03);
        wr8(PTC_OFS_CTL0, 8'h08);
        repeat (cyc) @(posedge clk);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        foreach (OFFS[i]) rdc(OFFS[i], 32'h0000_0000);
        wr8(PTC_OFS_DUTL, 8'ha5);
        rdc(PTC_OFS_DUTL, 32'h0000_00a5);
        wr8(PTC_OFS_DUTH, 8'hff);
        rdc(PTC_OFS_DUTH, 32'h0000_0003);
        wr8(PTC_OFS_PERL, 8'h5a);
        rdc(PTC_OFS_PERL, 32'h0000_005a);
        wr8(PTC_OFS_PERH, 8'hfe);
        rdc(PTC_OFS_PERH, 32'h0000_0002);
        wr8(PTC_OFS_CNTL, 8'h77);
        rdc(PTC_OFS_CNTL, 32'h0000_0000);
        wr8(6'h24, 8'h55);
        rdc(6'h24, 32'h0000_0000);
        wr8(PTC_OFS_DUTH, 8'h00);
        wr8(PTC_OFS_PERH, 8'h00);
        // pin is driven only in compare and pwm modes
        for (int m = 0; m < 4; m++)
        begin
            wr8(PTC_OFS_CTL1, {2'(m), 6'h00});
            @(negedge clk);
            check(32'(pin_en), 32'(m == 0 || m == 2));
            @(posedge clk);
        end
        // every output function against both initial levels
        for (int k = 0; k < 8; k++)
        begin
            io = 2'(k >> 1);
            oc = k[0];
            pol = k[2] ^ k[0];
            lvl = (io == 2'b00) ? oc : (io == 2'b01) ? 1'b0 :
                  (io == 2'b10) ? 1'b1 : ~oc;
            run({2'b00, io, oc, pol, 2'b00}, 8'h14, 8'h00, 0);
            pin_chk(oc ^ pol);
            wait_flag(PTC_DFLAG_BIT);
            pin_chk(lvl ^ pol);
            wr8(PTC_OFS_CTL0, 8'h00);
        end
        // period clears the counter, both flags
        run(8'h20, 8'h05, 8'h0c, 40);
        rdc(PTC_OFS_STAT, 32'h0000_0003);
        pin_chk(1'b1);
        wr8(PTC_OFS_CTL0, 8'h00);
        bus(1'b0, PTC_OFS_CNTL, 8'h00, v);
        check(32'(v <= 12), 32'h0000_0001);
        // duty clears the counter, period flag never set
        run(8'h01, 8'h0c, 8'h05, 40);
        rdc(PTC_OFS_STAT, 32'h0000_0001);
        wr8(PTC_OFS_CTL0, 8'h00);
        bus(1'b0, PTC_OFS_CNTL, 8'h00, v);
        check(32'(v <= 12), 32'h0000_0001);
        repeat (5) @(posedge clk);
        rdc(PTC_OFS_CNTL, v);
        wr8(PTC_OFS_CTL0, 8'h08);
        bus(1'b0, PTC_OFS_CNTL, 8'h00, v);
        check(32'(v < 8), 32'h0000_0001);
        wr8(PTC_OFS_CTL0, 8'h00);
        // zero compare values: overflow wrap, no flags
        run(8'h00, 8'h00, 8'h00, 1000);
        rdc(PTC_OFS_CNTH, 32'h0000_0003);
        repeat (40) @(posedge clk);
        rdc(PTC_OFS_CNTH, 32'h0000_0000);
        rdc(PTC_OFS_STAT, 32'h0000_0000);
        // stop first, so the next run restarts the counter from zero
        wr8(PTC_OFS_CTL0, 8'h00);
        // capture mode ignores clear select
        run(8'h71, 8'h05, 8'h0c, 40);
        bus(1'b0, PTC_OFS_STAT, 8'h00, v);
        check(32'(v[PTC_PFLAG_BIT]), 32'h0000_0001);
        wr8(PTC_OFS_CTL0, 8'h00);
        // every edge code on both sources; other pin must not capture
        for (int k = 0; k < 8; k++)
        begin
            io = 2'(k);
            run({2'b01, io, 2'b00, k[2], 1'b0}, 8'h00, 8'h00, 1);
            if (k[2]) ext_lvl <= 1'b1; else cap_lvl <= 1'b1;
            repeat (4) @(posedge clk);
            rdc(PTC_OFS_STAT, 32'(io == 2'b00 || io == 2'b10));
            wr8(PTC_OFS_STAT, 8'h03);
            if (k[2]) ext_lvl <= 1'b0; else cap_lvl <= 1'b0;
            repeat (4) @(posedge clk);
            rdc(PTC_OFS_STAT, 32'(io == 2'b01 || io == 2'b10));
            wr8(PTC_OFS_STAT, 8'h03);
            if (k[2]) cap_lvl <= 1'b1; else ext_lvl <= 1'b1;
            repeat (4) @(posedge clk);
            cap_lvl <= 1'b0;
            ext_lvl <= 1'b0;
            repeat (4) @(posedge clk);
            rdc(PTC_OFS_STAT, 32'h0000_0000);
            wr8(PTC_OFS_CTL0, 8'h00);
        end
        // pwm fixed levels while stopped: active, active inverted, inactive
        wr8(PTC_OFS_CTL1, 8'h98);
        pin_chk(1'b1);
        wr8(PTC_OFS_CTL1, 8'h9c);
        pin_chk(1'b0);
        wr8(PTC_OFS_CTL1, 8'h88);
        pin_chk(1'b0);
        final_report();
    end

    // hang guard
    initial
    begin
        repeat (60000) @(posedge clk);
        errors++;
        final_report();
    end
endmodule
